// ==== rtl/emb_pkg.sv ====
// Purpose: constants for the external memory strobe block
// Assumes: one clock, no register bus
// Notes: address and data widths are defaults of module parameters
package emb_pkg;
    localparam int EMB_ADDR_W = 24;
    localparam int EMB_DATA_W = 16;
    // pull-up enable bits for the select pins in the port d pull-up register
    localparam int EMB_PUR_W = 16;
    localparam int EMB_PUR_PS_BIT = 8;
    localparam int EMB_PUR_DS_BIT = 9;
    localparam logic [15:0] EMB_PUR_RST = 16'hFFFF;
    // strobe phase lengths in clock cycles
    localparam int EMB_SETUP_CYC = 1;
    localparam int EMB_STROBE_CYC = 2;
    localparam logic [7:0] EMB_CNT_ZERO = 8'h00;
    localparam logic [7:0] EMB_CNT_ONE = 8'h01;
    typedef enum logic [1:0] {
        EMB_IDLE,
        EMB_SETUP,
        EMB_STROBE,
        EMB_HOLD
    } emb_state_e;
endpackage : emb_pkg

// ==== rtl/emb_strobe_ctrl.sv ====
// Purpose: external memory bus strobes, selects and data pin direction
// Assumes: static ram or rom on the far side; inputs synchronous to clk_sys_i
// Notes: output enables are active low (low = pin driven)
// Overview of operation
// - read cycle: read strobe low, data pins become inputs.
// - read data captured when the read strobe returns high.
// - address, selects and chip selects valid while read strobe is low.
// - write cycle: write strobe low, data pins driven with write data.
// - address, selects and chip selects valid while write strobe is low.
// - with drive bit clear, strobes and selects float when bus idle.
// - strobe pull-ups off when the system pull-up disable bit is set.
// - chip select zero resets as program memory select, low on program access.
// - chip select one resets as data memory select, low on data access.
// - program select pin as port pin: pull-up off when bit 8 cleared.
// - data select pin as port pin: pull-up off when bit 9 cleared.
module emb_strobe_ctrl #(
    parameter int ADDR_W = emb_pkg::EMB_ADDR_W,
    parameter int DATA_W = emb_pkg::EMB_DATA_W,
    parameter int SETUP_CYC = emb_pkg::EMB_SETUP_CYC,
    parameter int STROBE_CYC = emb_pkg::EMB_STROBE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // request side
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic req_program_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [DATA_W-1:0] rsp_rdata_o,
    // configuration bits
    input wire logic bus_drive_bit_i,
    input wire logic strobe_pullup_disable_i,
    input wire logic [emb_pkg::EMB_PUR_W-1:0] port_d_pullup_enable_reg_i,
    input wire logic ps_is_gpio_i,
    input wire logic ds_is_gpio_i,
    // pins
    output logic [ADDR_W-1:0] address_lines_o,
    input wire logic [DATA_W-1:0] data_lines_i,
    output logic [DATA_W-1:0] data_lines_o,
    output logic data_lines_oe_n_o,
    output logic read_strobe_n_o,
    output logic read_strobe_oe_n_o,
    output logic read_strobe_pu_o,
    output logic write_strobe_n_o,
    output logic write_strobe_oe_n_o,
    output logic write_strobe_pu_o,
    output logic program_mem_select_n_o,
    output logic program_mem_select_oe_n_o,
    output logic program_mem_select_pu_o,
    output logic data_mem_select_n_o,
    output logic data_mem_select_oe_n_o,
    output logic data_mem_select_pu_o
);
    import emb_pkg::*;

    localparam logic [7:0] SETUP_LAST = 8'(SETUP_CYC - 1);
    localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

    emb_state_e state_r;
    logic [7:0] cnt_r;
    logic write_r;
    logic program_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] rdata_r;
    logic rsp_valid_r;
    logic rd_n_r;
    logic wr_n_r;
    logic ps_n_r;
    logic ds_n_r;
    logic ctl_oe_n_r;
    logic data_oe_n_r;
    logic ctl_oe_n_nxt;
    logic data_oe_n_nxt;
    logic sel_active;
    logic sel_program;

    ////////////////////////////////////////////////////////////////////////
    // cycle sequencer: setup, strobe low, hold with strobe high
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= EMB_IDLE;
            cnt_r <= EMB_CNT_ZERO;
        end else begin
            unique case (state_r)
                EMB_IDLE: begin
                    if (req_valid_i) begin
                        state_r <= EMB_SETUP;
                        cnt_r <= EMB_CNT_ZERO;
                    end
                end
                EMB_SETUP: begin
                    if (cnt_r >= SETUP_LAST) begin
                        state_r <= EMB_STROBE;
                        cnt_r <= EMB_CNT_ZERO;
                    end else begin
                        cnt_r <= cnt_r + EMB_CNT_ONE;
                    end
                end
                EMB_STROBE: begin
                    if (cnt_r >= STROBE_LAST) begin
                        state_r <= EMB_HOLD;
                        cnt_r <= EMB_CNT_ZERO;
                    end else begin
                        cnt_r <= cnt_r + EMB_CNT_ONE;
                    end
                end
                EMB_HOLD: begin
                    state_r <= EMB_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request capture; address and data held for the whole cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_r <= 1'b0;
            program_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
        end else if (state_r == EMB_IDLE && req_valid_i) begin
            write_r <= req_write_i;
            program_r <= req_program_i;
            addr_r <= req_addr_i;
            wdata_r <= req_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // select window and target memory, taken straight from the request at the take
    always_comb begin
        sel_active = 1'b0;
        sel_program = program_r;
        if (state_r == EMB_IDLE) begin
            sel_active = req_valid_i;
            sel_program = req_program_i;
        end else if (state_r == EMB_SETUP || state_r == EMB_STROBE) begin
            sel_active = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobes and selects; selects span setup to hold so they frame the strobe
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            ps_n_r <= 1'b1;
            ds_n_r <= 1'b1;
        end else begin
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            ps_n_r <= 1'b1;
            ds_n_r <= 1'b1;
            if (state_r == EMB_SETUP && cnt_r >= SETUP_LAST) begin
                rd_n_r <= write_r;
                wr_n_r <= !write_r;
            end else if (state_r == EMB_STROBE && cnt_r < STROBE_LAST) begin
                rd_n_r <= rd_n_r;
                wr_n_r <= wr_n_r;
            end
            if (sel_active) begin
                // the select stays low one cycle past the strobe rise
                ps_n_r <= !sel_program;
                ds_n_r <= sel_program;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control pin enable: with the drive bit clear the controls only drive
    // while an access is under way, so idle pins sit on their pull-ups
    always_comb begin
        ctl_oe_n_nxt = 1'b1;
        if (bus_drive_bit_i) begin
            // drive bit set: controls stay driven between accesses as well
            ctl_oe_n_nxt = 1'b0;
        end else begin
            unique case (state_r)
                EMB_IDLE: begin
                    // start driving at the take so the select edge is driven, not pulled
                    ctl_oe_n_nxt = !req_valid_i;
                end
                EMB_SETUP: begin
                    ctl_oe_n_nxt = 1'b0;
                end
                EMB_STROBE: begin
                    ctl_oe_n_nxt = 1'b0;
                end
                EMB_HOLD: begin
                    // released together with the select rise; the pull-ups carry the pins high
                    ctl_oe_n_nxt = !req_valid_i;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data pin enable: driven from the write strobe fall to one cycle past
    // the write strobe rise, so the memory sees stable data as it latches
    always_comb begin
        data_oe_n_nxt = 1'b1;
        if (write_r) begin
            if (state_r == EMB_SETUP && cnt_r >= SETUP_LAST) begin
                data_oe_n_nxt = 1'b0;
            end else if (state_r == EMB_STROBE) begin
                data_oe_n_nxt = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin enables registered so the pins never see decode glitches
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_oe_n_r <= 1'b1;
            data_oe_n_r <= 1'b1;
        end else begin
            ctl_oe_n_r <= ctl_oe_n_nxt;
            data_oe_n_r <= data_oe_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data latched on the read strobe rising edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= '0;
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= 1'b0;
            if (state_r == EMB_STROBE && cnt_r >= STROBE_LAST && !write_r) begin
                rdata_r <= data_lines_i;
                rsp_valid_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign req_ready_o = (state_r == EMB_IDLE);
    assign rsp_valid_o = rsp_valid_r;
    assign rsp_rdata_o = rdata_r;
    assign address_lines_o = addr_r;
    assign data_lines_o = wdata_r;
    assign data_lines_oe_n_o = data_oe_n_r;
    assign read_strobe_n_o = rd_n_r;
    assign write_strobe_n_o = wr_n_r;
    assign program_mem_select_n_o = ps_n_r;
    assign data_mem_select_n_o = ds_n_r;
    assign read_strobe_oe_n_o = ctl_oe_n_r;
    assign write_strobe_oe_n_o = ctl_oe_n_r;

    ////////////////////////////////////////////////////////////////////////
    // select pin enables: a pin handed to the port logic is never driven here
    always_comb begin
        program_mem_select_oe_n_o = ctl_oe_n_r;
        if (ps_is_gpio_i) begin
            program_mem_select_oe_n_o = 1'b1;
        end
    end

    always_comb begin
        data_mem_select_oe_n_o = ctl_oe_n_r;
        if (ds_is_gpio_i) begin
            data_mem_select_oe_n_o = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pull-ups: forced on while reset is held, because the enable inputs
    // come from registers that are themselves in reset
    always_comb begin
        read_strobe_pu_o = 1'b1;
        write_strobe_pu_o = 1'b1;
        if (rst_n_i) begin
            read_strobe_pu_o = !strobe_pullup_disable_i;
            write_strobe_pu_o = !strobe_pullup_disable_i;
        end
    end

    // as a bus select the pin keeps its pull-up so it floats high when released
    always_comb begin
        program_mem_select_pu_o = 1'b1;
        if (rst_n_i && ps_is_gpio_i) begin
            program_mem_select_pu_o = port_d_pullup_enable_reg_i[EMB_PUR_PS_BIT];
        end
    end

    always_comb begin
        data_mem_select_pu_o = 1'b1;
        if (rst_n_i && ds_is_gpio_i) begin
            data_mem_select_pu_o = port_d_pullup_enable_reg_i[EMB_PUR_DS_BIT];
        end
    end
endmodule : emb_strobe_ctrl

// ==== tb/emb_strobe_ctrl_assertions.sv ====
// Purpose: pin checks for the strobe block
// Assumes: setup 1 and strobe 2 cycles
// Notes: bound into the block below
module emb_strobe_ctrl_assertions #(
    parameter int DATA_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic req_program_i,
    input wire logic req_ready_o,
    input wire logic bus_drive_bit_i,
    input wire logic rsp_valid_o,
    input wire logic [DATA_W-1:0] rsp_rdata_o,
    input wire logic [DATA_W-1:0] data_lines_i,
    input wire logic data_lines_oe_n_o,
    input wire logic read_strobe_n_o,
    input wire logic read_strobe_oe_n_o,
    input wire logic write_strobe_n_o,
    input wire logic write_strobe_oe_n_o,
    input wire logic program_mem_select_n_o,
    input wire logic data_mem_select_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire logic take = req_valid_i && req_ready_o;
    // three quiet cycles in a row, so the registered enables have settled
    wire logic quiet = req_ready_o && !req_valid_i && !bus_drive_bit_i;
    ////////////////////////////////////////////////////////////////
    rd_walk_a: assert property (take && !req_write_i |-> ##2 (!read_strobe_n_o && data_lines_oe_n_o) [*2]
        ##1 read_strobe_n_o) else $error("read strobe walk wrong");
    rd_capture_a: assert property ($rose(read_strobe_n_o) |-> rsp_valid_o &&
        rsp_rdata_o == $past(data_lines_i)) else $error("read data not captured");
    rd_qualify_a: assert property (!read_strobe_n_o |-> !read_strobe_oe_n_o &&
        (program_mem_select_n_o != data_mem_select_n_o)) else $error("read not qualified");
    wr_walk_a: assert property (take && req_write_i |-> ##2 (!write_strobe_n_o && !data_lines_oe_n_o) [*2]
        ##1 write_strobe_n_o) else $error("write strobe walk wrong");
    wr_qualify_a: assert property (!write_strobe_n_o |-> !write_strobe_oe_n_o &&
        (program_mem_select_n_o != data_mem_select_n_o)) else $error("write not qualified");
    idle_float_a: assert property (quiet && $past(quiet) && $past(quiet, 2) |->
        read_strobe_oe_n_o && write_strobe_oe_n_o) else $error("idle strobes driven");
    prog_sel_a: assert property (take && req_program_i |-> ##1 (!program_mem_select_n_o &&
        data_mem_select_n_o) [*4] ##1 program_mem_select_n_o) else $error("program select wrong");
    data_sel_a: assert property (take && !req_program_i |-> ##1 (!data_mem_select_n_o &&
        program_mem_select_n_o) [*4] ##1 data_mem_select_n_o) else $error("data select wrong");
    rd_cov: cover property (take && !req_write_i);
    wr_cov: cover property (take && req_write_i);
    prog_cov: cover property (take && req_program_i);
endmodule : emb_strobe_ctrl_assertions
bind emb_strobe_ctrl emb_strobe_ctrl_assertions #(.DATA_W(DATA_W)) u_emb_strobe_ctrl_assertions (.*);

// ==== tb/emb_sram_model.sv ====
// Purpose: static memory on one select line
// Assumes: strobes and select active low
// Notes: released data shows a walking pattern
module emb_sram_model #(
    parameter int DLY = 3
) (
    input wire logic clk_i,
    input wire logic [emb_pkg::EMB_ADDR_W-1:0] addr_i,
    input wire logic [emb_pkg::EMB_DATA_W-1:0] wdata_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic sel_n_i,
    output logic [emb_pkg::EMB_DATA_W-1:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import emb_pkg::*;
    logic [EMB_DATA_W-1:0] mem_r [16];
    logic [EMB_DATA_W-1:0] junk_r = 16'h1234;
    always @(posedge clk_i) junk_r <= {junk_r[14:0], ~junk_r[15]};
    always @(posedge we_n_i) if (!sel_n_i) mem_r[addr_i[3:0]] = wdata_i;
    assign #(DLY) rdata_o = (!oe_n_i && !sel_n_i) ? mem_r[addr_i[3:0]] : junk_r;
endmodule : emb_sram_model

// ==== tb/emb_strobe_ctrl_bench.sv ====
// Purpose: self-checking bench for the strobe block
// Assumes: default cycle counts
// Notes: inputs change on the falling edge
module emb_strobe_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import emb_pkg::*;
    logic clk_sys_i, rst_n_i, req_valid_i, req_write_i, req_program_i, bus_drive_bit_i, strobe_pullup_disable_i;
    logic ps_is_gpio_i, ds_is_gpio_i, req_ready_o, rsp_valid_o, data_lines_oe_n_o, read_strobe_n_o;
    logic read_strobe_oe_n_o, read_strobe_pu_o, write_strobe_n_o, write_strobe_oe_n_o, write_strobe_pu_o;
    logic program_mem_select_n_o, program_mem_select_oe_n_o, program_mem_select_pu_o;
    logic data_mem_select_n_o, data_mem_select_oe_n_o, data_mem_select_pu_o;
    logic [EMB_ADDR_W-1:0] req_addr_i, address_lines_o;
    logic [EMB_DATA_W-1:0] req_wdata_i, rsp_rdata_o, data_lines_i, data_lines_o, p_rd, d_rd;
    logic [EMB_PUR_W-1:0] port_d_pullup_enable_reg_i;
    int failures = 0;
    int comparisons = 0;
    emb_strobe_ctrl u_emb_strobe_ctrl (.*);
    emb_sram_model u_emb_sram_model_p (.clk_i(clk_sys_i), .addr_i(address_lines_o), .wdata_i(data_lines_o),
        .oe_n_i(read_strobe_n_o), .we_n_i(write_strobe_n_o), .sel_n_i(program_mem_select_n_o), .rdata_o(p_rd));
    emb_sram_model u_emb_sram_model_d (.clk_i(clk_sys_i), .addr_i(address_lines_o), .wdata_i(data_lines_o),
        .oe_n_i(read_strobe_n_o), .we_n_i(write_strobe_n_o), .sel_n_i(data_mem_select_n_o), .rdata_o(d_rd));
    assign data_lines_i = program_mem_select_n_o ? d_rd : p_rd;
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("counts: %0d compared, %0d bad", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // bounded wait for ready (rsp=0) or read data (rsp=1)
    task automatic wait_hi(input bit rsp);
        for (int n = 0; (rsp ? rsp_valid_o : req_ready_o) !== 1'b1; n++) begin
            if (n > 20) begin
                failures++;
                print_verdict();
            end
            @(negedge clk_sys_i);
        end
    endtask : wait_hi
    task automatic access(input logic wr, input logic prog, input logic [15:0] wd);
        wait_hi(1'b0);
        {req_valid_i, req_write_i, req_program_i, req_addr_i, req_wdata_i} = {1'b1, wr, prog, 24'h00_0005, wd};
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        if (!wr) wait_hi(1'b1);
    endtask : access
    ////////////////////////////////////////////////////////////////
    task automatic test_pullups();
        {ps_is_gpio_i, ds_is_gpio_i} = 2'h3;
        for (int i = 0; i < 2; i++) begin
            strobe_pullup_disable_i = i[0];
            port_d_pullup_enable_reg_i = i[0] ? 16'hFEFF : 16'hFDFF;
            @(negedge clk_sys_i);
            check({read_strobe_pu_o, write_strobe_pu_o}, {2{~i[0]}});
            check({program_mem_select_pu_o, data_mem_select_pu_o}, {~i[0], i[0]});
        end
        {ps_is_gpio_i, ds_is_gpio_i, strobe_pullup_disable_i} = 3'h0;
        $display("test pullups done");
    endtask : test_pullups
    task automatic test_rw();
        access(1'b1, 1'b0, 16'hA5C3);
        access(1'b1, 1'b1, 16'h3C5A);
        access(1'b0, 1'b0, 16'h0000);
        check(rsp_rdata_o, 16'hA5C3);
        access(1'b0, 1'b1, 16'h0000);
        check(rsp_rdata_o, 16'h3C5A);
        repeat (3) @(negedge clk_sys_i);
        check({read_strobe_oe_n_o, write_strobe_oe_n_o, program_mem_select_oe_n_o}, 3'h7);
        bus_drive_bit_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        check({read_strobe_oe_n_o, write_strobe_oe_n_o, program_mem_select_oe_n_o}, 3'h0);
        $display("test rw done");
    endtask : test_rw
    // write at a fresh address and watch the pins cycle by cycle
    task automatic test_pins();
        wait_hi(1'b0);
        {req_valid_i, req_write_i, req_program_i, req_addr_i, req_wdata_i} = {3'h6, 24'h00_0009, 16'h5AA5};
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        check(address_lines_o, 24'h00_0009);
        check({write_strobe_n_o, data_mem_select_n_o, program_mem_select_n_o, data_lines_oe_n_o}, 4'hB);
        repeat (2) begin
            @(negedge clk_sys_i);
            check({write_strobe_n_o, data_mem_select_n_o, program_mem_select_n_o, data_lines_oe_n_o}, 4'h2);
            check(data_lines_o, 16'h5AA5);
        end
        @(negedge clk_sys_i);
        check({write_strobe_n_o, data_mem_select_n_o, program_mem_select_n_o, data_lines_oe_n_o}, 4'hA);
        @(negedge clk_sys_i);
        check({write_strobe_n_o, data_mem_select_n_o, read_strobe_n_o, data_lines_oe_n_o}, 4'hF);
        {ps_is_gpio_i, ds_is_gpio_i} = 2'h3;
        @(negedge clk_sys_i);
        check({program_mem_select_oe_n_o, data_mem_select_oe_n_o, write_strobe_oe_n_o}, 3'h6);
        {ps_is_gpio_i, ds_is_gpio_i} = 2'h0;
        $display("test pins done");
    endtask : test_pins
    initial begin
        {rst_n_i, req_valid_i, req_write_i, req_program_i, bus_drive_bit_i, ps_is_gpio_i, ds_is_gpio_i} = 7'h00;
        {strobe_pullup_disable_i, req_addr_i, req_wdata_i} = {1'b1, 40'h00_0000_0000};
        port_d_pullup_enable_reg_i = EMB_PUR_RST;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check({read_strobe_oe_n_o, program_mem_select_oe_n_o, data_lines_oe_n_o, req_ready_o}, 4'hF);
        check({read_strobe_pu_o, write_strobe_pu_o, data_mem_select_pu_o, rsp_valid_o}, 4'hE);
        $display("test reset done");
        rst_n_i = 1'b1;
        test_pullups();
        test_rw();
        test_pins();
        print_verdict();
    end
endmodule : emb_strobe_ctrl_bench
